// *** common/gcrb_pkg.sv ***
// global configuration register bank: shared constants
// assumes one clock domain and a serial front end that delivers whole register accesses
package gcrb_pkg;
	// register access
	localparam int ADDR_W = 8; // address width of one access
	localparam int DATA_W = 32; // data width of one access
	localparam logic [7:0] WRITE_FLAG = 8'h80; // added to the address to mark a write
	localparam logic [6:0] CFG_OFS = 7'h00; // global configuration register offset
	localparam int CFG_W = 12; // width of the global configuration register
	localparam logic [11:0] CFG_RESET = 12'h000; // power-up value of the configuration
	// field positions in the global configuration register
	localparam int BIT_PARALLEL = 0; // one motor at double current
	localparam int BIT_AXIS1_EXT = 1; // axis 1 from external step and direction
	localparam int BIT_AXIS2_EXT = 2; // axis 2 from external step and direction
	// driver settings word width
	localparam int SET_W = 8;
	localparam logic [7:0] SET_RESET = 8'h00; // driver settings after reset
endpackage

// *** hw/gcrb_axis_sel.sv ***
// axis motion source selector: ramp generator or external step and direction
// assumes all inputs are synchronous to the system clock
`timescale 1ns/1ps
module gcrb_axis_sel (
	input wire logic ext_sel,
	input wire logic ramp_step,
	input wire logic ramp_dir,
	input wire logic ext_step,
	input wire logic ext_dir,
	output logic sel_step,
	output logic sel_dir,
	output logic ramp_en
);
	// pick the source and park the ramp generator when it is bypassed
	always_comb begin
		if (ext_sel) begin
			sel_step = ext_step;
			sel_dir = ext_dir;
			ramp_en = 1'b0; // RULE_08 RULE_10
		end else begin
			sel_step = ramp_step;
			sel_dir = ramp_dir;
			ramp_en = 1'b1; // RULE_07 RULE_09
		end
	end
endmodule

// *** hw/gcrb_top.sv ***
// global configuration register bank with axis source and driver stage routing
// assumes the serial front end delivers one register access per REG_VALID pulse
// How it works
// [RULE_01] power-up clears every register to zero
// [RULE_02] address plus 0x80 writes, otherwise reads
// [RULE_03] bit 0 clear: two independent driver stages
// [RULE_04] bit 0 set: stage two copies stage one
// [RULE_05] paralleled mode ignores second driver settings
// [RULE_06] host sets parallel bit before driver enable
// [RULE_07] bit 1 clear: axis 1 from ramp 1
// [RULE_08] bit 1 set: axis 1 external, ramp 1 idle
// [RULE_09] bit 2 clear: axis 2 from ramp 2
// [RULE_10] bit 2 set: axis 2 external, ramp 2 idle
// [RULE_11] read returns last written value, zero initially
`timescale 1ns/1ps
module gcrb_top #(
	parameter int CFG_W = gcrb_pkg::CFG_W,
	parameter int SET_W = gcrb_pkg::SET_W
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic REG_VALID,
	input wire logic [gcrb_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic [gcrb_pkg::DATA_W-1:0] REG_WDATA,
	output logic REG_RVALID,
	output logic [gcrb_pkg::DATA_W-1:0] REG_RDATA,
	input wire logic RAMP1_STEP,
	input wire logic RAMP1_DIR,
	input wire logic RAMP2_STEP,
	input wire logic RAMP2_DIR,
	input wire logic AXIS1_STEP_INPUT,
	input wire logic AXIS1_DIR_INPUT,
	input wire logic AXIS2_STEP_INPUT,
	input wire logic AXIS2_DIR_INPUT,
	input wire logic [SET_W-1:0] DRV1_SETTINGS_IN,
	input wire logic [SET_W-1:0] DRV2_SETTINGS_IN,
	output logic RAMP1_ENABLE,
	output logic RAMP2_ENABLE,
	output logic DRV1_STEP,
	output logic DRV1_DIR,
	output logic DRV2_STEP,
	output logic DRV2_DIR,
	output logic [SET_W-1:0] DRV1_SETTINGS,
	output logic [SET_W-1:0] DRV2_SETTINGS,
	output logic PARALLEL_MODE
);
	// the field positions and read path assume these widths
	if (CFG_W < 3 || CFG_W > gcrb_pkg::DATA_W) begin : g_bad_cfg_w
		$error("CFG_W out of range");
	end
	if (SET_W < 1) begin : g_bad_set_w
		$error("SET_W out of range");
	end

	// configuration register and read answer
	logic [CFG_W-1:0] cfg_r, cfg_nxt; // global configuration bits
	logic rvalid_r, rvalid_nxt; // read answer strobe
	logic [gcrb_pkg::DATA_W-1:0] rdata_r, rdata_nxt; // read answer data
	// driver stage outputs
	logic d1_step_r, d1_step_nxt;
	logic d1_dir_r, d1_dir_nxt;
	logic d2_step_r, d2_step_nxt;
	logic d2_dir_r, d2_dir_nxt;
	logic [SET_W-1:0] s1_r, s1_nxt; // effective driver 1 settings
	logic [SET_W-1:0] s2_r, s2_nxt; // effective driver 2 settings
	// per-axis selected motion and ramp usage
	logic [1:0] ax_ext; // external control per axis
	logic [1:0] ax_step; // selected step per axis
	logic [1:0] ax_dir; // selected direction per axis
	logic [1:0] ax_ramp_en; // ramp generator in use per axis
	logic [1:0] ramp_step_v;
	logic [1:0] ramp_dir_v;
	logic [1:0] ext_step_v;
	logic [1:0] ext_dir_v;
	logic parallel; // one motor at double current

	// decode of the access: base offset only, the write mark bit is ignored
	function automatic logic hits(input logic [gcrb_pkg::ADDR_W-1:0] a,
		input logic [6:0] ofs);
		hits = (a[6:0] == ofs);
	endfunction

	assign parallel = cfg_r[gcrb_pkg::BIT_PARALLEL];
	assign ax_ext[0] = cfg_r[gcrb_pkg::BIT_AXIS1_EXT];
	assign ax_ext[1] = cfg_r[gcrb_pkg::BIT_AXIS2_EXT];
	assign ramp_step_v = {RAMP2_STEP, RAMP1_STEP};
	assign ramp_dir_v = {RAMP2_DIR, RAMP1_DIR};
	assign ext_step_v = {AXIS2_STEP_INPUT, AXIS1_STEP_INPUT};
	assign ext_dir_v = {AXIS2_DIR_INPUT, AXIS1_DIR_INPUT};

	// one source selector per axis
	for (genvar i = 0; i < 2; i++) begin : g_axis
		gcrb_axis_sel u_sel (
			.ext_sel(ax_ext[i]), // RULE_07 RULE_08 RULE_09 RULE_10
			.ramp_step(ramp_step_v[i]),
			.ramp_dir(ramp_dir_v[i]),
			.ext_step(ext_step_v[i]),
			.ext_dir(ext_dir_v[i]),
			.sel_step(ax_step[i]),
			.sel_dir(ax_dir[i]),
			.ramp_en(ax_ramp_en[i])
		);
	end

	// register access: write when the mark is present, read otherwise
	always_comb begin
		cfg_nxt = cfg_r;
		rvalid_nxt = 1'b0;
		rdata_nxt = rdata_r;
		if (REG_VALID) begin
			if ((REG_ADDR & gcrb_pkg::WRITE_FLAG) != 8'h00) begin
				// write to the base register
				if (hits(REG_ADDR, gcrb_pkg::CFG_OFS)) begin
					cfg_nxt = REG_WDATA[CFG_W-1:0]; // RULE_02
				end
			end else begin
				// read: unmapped offsets answer zero
				rvalid_nxt = 1'b1;
				rdata_nxt = '0;
				if (hits(REG_ADDR, gcrb_pkg::CFG_OFS)) begin
					rdata_nxt[CFG_W-1:0] = cfg_r; // RULE_11
				end
			end
		end
	end

	// register bank flip-flops
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			cfg_r <= CFG_W'(gcrb_pkg::CFG_RESET); // RULE_01
			rvalid_r <= 1'b0;
			rdata_r <= '0; // RULE_01
		end else begin
			cfg_r <= cfg_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// driver stage routing
	always_comb begin
		d1_step_nxt = ax_step[0];
		d1_dir_nxt = ax_dir[0];
		s1_nxt = DRV1_SETTINGS_IN;
		if (parallel) begin
			// second stage mirrors the first
			d2_step_nxt = ax_step[0]; // RULE_04
			d2_dir_nxt = ax_dir[0]; // RULE_04
			s2_nxt = DRV1_SETTINGS_IN; // RULE_05
		end else begin
			// independent second axis
			d2_step_nxt = ax_step[1]; // RULE_03
			d2_dir_nxt = ax_dir[1]; // RULE_03
			s2_nxt = DRV2_SETTINGS_IN; // RULE_03
		end
	end

	// driver stage flip-flops
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			d1_step_r <= 1'b0;
			d1_dir_r <= 1'b0;
			d2_step_r <= 1'b0;
			d2_dir_r <= 1'b0;
			s1_r <= SET_W'(gcrb_pkg::SET_RESET); // RULE_01
			s2_r <= SET_W'(gcrb_pkg::SET_RESET); // RULE_01
		end else begin
			d1_step_r <= d1_step_nxt;
			d1_dir_r <= d1_dir_nxt;
			d2_step_r <= d2_step_nxt;
			d2_dir_r <= d2_dir_nxt;
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	// outputs
	assign REG_RVALID = rvalid_r;
	assign REG_RDATA = rdata_r;
	assign DRV1_STEP = d1_step_r;
	assign DRV1_DIR = d1_dir_r;
	assign DRV2_STEP = d2_step_r;
	assign DRV2_DIR = d2_dir_r;
	assign DRV1_SETTINGS = s1_r;
	assign DRV2_SETTINGS = s2_r;
	assign RAMP1_ENABLE = ax_ramp_en[0];
	assign RAMP2_ENABLE = ax_ramp_en[1];
	// the host must settle this before enabling the drivers
	assign PARALLEL_MODE = parallel; // RULE_06

	// checks
	property p_reset_zero;
		@(posedge CLK_SYS) RST |=> (cfg_r == '0) && !REG_RVALID;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("config not cleared"); // RULE_01

	property p_write;
		@(posedge CLK_SYS) disable iff (RST)
		REG_VALID && REG_ADDR == (gcrb_pkg::WRITE_FLAG | {1'b0, gcrb_pkg::CFG_OFS})
		|=> cfg_r == $past(REG_WDATA[CFG_W-1:0]) && !REG_RVALID;
	endproperty
	a_write: assert property (p_write) else $error("write not stored"); // RULE_02

	property p_read_keeps;
		@(posedge CLK_SYS) disable iff (RST)
		REG_VALID && !REG_ADDR[7] |=> $stable(cfg_r) && REG_RVALID;
	endproperty
	a_read_keeps: assert property (p_read_keeps) else $error("read disturbed config"); // RULE_02

	property p_readback;
		@(posedge CLK_SYS) disable iff (RST)
		REG_VALID && REG_ADDR == {1'b0, gcrb_pkg::CFG_OFS}
		|=> REG_RDATA[CFG_W-1:0] == $past(cfg_r) && REG_RVALID;
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch"); // RULE_11

	property p_indep;
		@(posedge CLK_SYS) disable iff (RST)
		!parallel |=> DRV2_STEP == $past(ax_step[1]) && DRV2_SETTINGS == $past(DRV2_SETTINGS_IN);
	endproperty
	a_indep: assert property (p_indep) else $error("stage two not independent"); // RULE_03

	property p_mirror;
		@(posedge CLK_SYS) disable iff (RST)
		parallel |=> DRV2_STEP == DRV1_STEP && DRV2_DIR == DRV1_DIR;
	endproperty
	a_mirror: assert property (p_mirror) else $error("stage two not mirrored"); // RULE_04

	property p_ignore2;
		@(posedge CLK_SYS) disable iff (RST)
		parallel |=> DRV2_SETTINGS == $past(DRV1_SETTINGS_IN);
	endproperty
	a_ignore2: assert property (p_ignore2) else $error("axis 2 settings used"); // RULE_05

	property p_ax1_ramp;
		@(posedge CLK_SYS) disable iff (RST)
		!ax_ext[0] |-> RAMP1_ENABLE ##1 DRV1_STEP == $past(RAMP1_STEP);
	endproperty
	a_ax1_ramp: assert property (p_ax1_ramp) else $error("axis 1 not from ramp"); // RULE_07

	property p_ax1_ext;
		@(posedge CLK_SYS) disable iff (RST)
		ax_ext[0] |-> !RAMP1_ENABLE ##1 DRV1_DIR == $past(AXIS1_DIR_INPUT);
	endproperty
	a_ax1_ext: assert property (p_ax1_ext) else $error("axis 1 not external"); // RULE_08

	property p_ax2_ramp;
		@(posedge CLK_SYS) disable iff (RST)
		!ax_ext[1] && !parallel |-> RAMP2_ENABLE ##1 DRV2_STEP == $past(RAMP2_STEP);
	endproperty
	a_ax2_ramp: assert property (p_ax2_ramp) else $error("axis 2 not from ramp"); // RULE_09

	property p_ax2_ext;
		@(posedge CLK_SYS) disable iff (RST)
		ax_ext[1] && !parallel |-> !RAMP2_ENABLE ##1 DRV2_DIR == $past(AXIS2_DIR_INPUT);
	endproperty
	a_ax2_ext: assert property (p_ax2_ext) else $error("axis 2 not external"); // RULE_10

	c_write: cover property (@(posedge CLK_SYS) disable iff (RST) REG_VALID && REG_ADDR[7]);
	c_parallel: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(parallel));
	c_ext_both: cover property (@(posedge CLK_SYS) disable iff (RST) ax_ext == 2'b11);
	c_read: cover property (@(posedge CLK_SYS) disable iff (RST) REG_RVALID && REG_RDATA != '0);
endmodule

// *** tb/gcrb_host.sv ***
// host side model: issues register accesses over the access port
// assumes the bank takes one access per clock edge with REG_VALID high
`timescale 1ns/1ps
module gcrb_host (
	input wire logic clk,
	output logic reg_valid,
	output logic [7:0] reg_addr,
	output logic [31:0] reg_wdata,
	input wire logic reg_rvalid,
	input wire logic [31:0] reg_rdata
);
	// idle bus at time zero
	initial begin
		reg_valid = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
	end
	// one access held over its taking edge, then lines show inverted junk
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_valid <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_valid <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// write: offset marked by the write flag; config goes in before motion
	task automatic wr(input logic [6:0] ofs, input logic [31:0] d);
		put({1'b0, ofs} + 8'h80, d);
	endtask
	// read: plain offset; the strobe must show right after the taking edge,
	// stand for one cycle only, and the data must hold after it drops
	task automatic rd(input logic [6:0] ofs, output logic [31:0] d, output logic ok);
		put({1'b0, ofs}, 32'h0000_0000);
		#1;
		ok = (reg_rvalid === 1'b1);
		d = reg_rdata;
		@(posedge clk);
		#1;
		if (reg_rvalid !== 1'b0 || reg_rdata !== d) begin
			ok = 1'b0;
		end
	endtask
endmodule

// *** tb/tb.sv ***
// testbench for the configuration bank: reset, access, routing
// assumes gcrb_host drives the access port
`timescale 1ns/1ps
module tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic reg_valid, reg_rvalid;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic r1s, r1d, r2s, r2d, e1s, e1d, e2s, e2d;
	logic [7:0] s1, s2, o1, o2;
	logic re1, re2, d1s, d1d, d2s, d2d, par;
	int mismatches = 0;
	int n_checks = 0;
	// 50 ns system clock
	always #25 clk_sys = ~clk_sys;
	gcrb_top u_dut (.CLK_SYS(clk_sys), .RST(rst), .REG_VALID(reg_valid), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_RVALID(reg_rvalid), .REG_RDATA(reg_rdata),
		.RAMP1_STEP(r1s), .RAMP1_DIR(r1d), .RAMP2_STEP(r2s), .RAMP2_DIR(r2d),
		.AXIS1_STEP_INPUT(e1s), .AXIS1_DIR_INPUT(e1d), .AXIS2_STEP_INPUT(e2s),
		.AXIS2_DIR_INPUT(e2d), .DRV1_SETTINGS_IN(s1), .DRV2_SETTINGS_IN(s2),
		.RAMP1_ENABLE(re1), .RAMP2_ENABLE(re2), .DRV1_STEP(d1s), .DRV1_DIR(d1d),
		.DRV2_STEP(d2s), .DRV2_DIR(d2d), .DRV1_SETTINGS(o1), .DRV2_SETTINGS(o2),
		.PARALLEL_MODE(par));
	gcrb_host u_host (.clk(clk_sys), .reg_valid(reg_valid), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata));
	// compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// read one offset and judge strobe and data
	task automatic rd_chk(input string what, input logic [6:0] ofs, input logic [31:0] exp);
		logic [31:0] d;
		logic ok;
		u_host.rd(ofs, d, ok);
		chk({what, " strobe"}, 32'h0000_0001, {31'h0, ok});
		chk(what, exp, d);
	endtask
	// verdict and end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// values right after reset
	task automatic t_reset;
		rd_chk("cfg at reset", 7'h00, 32'h0000_0000);
		chk("parallel at reset", 32'h0000_0000, {31'h0, par});
		chk("ramp enables at reset", 32'h0000_0003, {30'h0, re1, re2});
		$display("test reset done");
	endtask
	// readback, foreign offsets, reset in mid-run
	task automatic t_rw;
		u_host.wr(7'h00, 32'hFFFF_FABC);
		rd_chk("cfg readback", 7'h00, 32'h0000_0ABC);
		u_host.wr(7'h05, 32'h0000_0123);
		rd_chk("cfg kept", 7'h00, 32'h0000_0ABC);
		rd_chk("other offset", 7'h05, 32'h0000_0000);
		@(posedge clk_sys);
		rst <= 1'b1;
		// live inputs show that reset, not the inputs, clears the stages
		s1 <= 8'hA5;
		{r1s, r1d} <= 2'b11;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("stages in reset", 32'h0000_0000, {13'h0, par, o1, o2, d1s, d1d});
		@(posedge clk_sys);
		rst <= 1'b0;
		s1 <= 8'h00;
		{r1s, r1d} <= 2'b00;
		rd_chk("cfg after reset", 7'h00, 32'h0000_0000);
		$display("test access done");
	endtask
	// every source mode, two opposite input patterns
	task automatic t_route;
		logic [1:0] x1, x2;
		logic [7:0] st2;
		for (int c = 0; c < 8; c++) begin
			for (int p = 0; p < 2; p++) begin
				u_host.wr(7'h00, {29'h0, c[2:0]});
				@(posedge clk_sys);
				{r1s, r1d, r2s, r2d, e1s, e1d, e2s, e2d} <= 8'hB4 ^ {8{p[0]}};
				s1 <= 8'hA5 ^ {8{p[0]}};
				s2 <= 8'h3C ^ {8{p[0]}};
				// one edge only: the stages answer with a latency of exactly one cycle
				@(posedge clk_sys);
				#1;
				x1 = c[1] ? {e1s, e1d} : {r1s, r1d};
				x2 = c[0] ? x1 : (c[2] ? {e2s, e2d} : {r2s, r2d});
				st2 = c[0] ? s1 : s2;
				chk("stage1 motion", {30'h0, x1}, {30'h0, d1s, d1d});
				chk("stage2 motion", {30'h0, x2}, {30'h0, d2s, d2d});
				chk("stage1 settings", {24'h0, s1}, {24'h0, o1});
				chk("stage2 settings", {24'h0, st2}, {24'h0, o2});
				chk("ramp enables", {30'h0, ~c[1], ~c[2]}, {30'h0, re1, re2});
				chk("parallel", {31'h0, c[0]}, {31'h0, par});
			end
		end
		$display("test routing done");
	endtask
	// main sequence
	initial begin
		{r1s, r1d, r2s, r2d, e1s, e1d, e2s, e2d} = 8'h00;
		s1 = 8'h00;
		s2 = 8'h00;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset;
		t_rw;
		t_route;
		close_out;
	end
	// watchdog, far beyond the some 90 cycles the tests need
	initial begin
		#(50 * 4000);
		mismatches++;
		close_out;
	end
endmodule
